// ---- rtl/mbt_pkg.sv ----
// Purpose: shared constants and state record of the register server
// Assumes: one 20 MHz clock, frames arrive one byte per handshake
// Notes:   all supported queries are twelve bytes long
package mbt_pkg;
    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int unsigned QRY_BYTES = 12;
    localparam int unsigned HDR_BYTES = 9;
    localparam logic [3:0]  POS_PROTO = 4'h2;
    localparam logic [3:0]  POS_LEN   = 4'h4;
    localparam logic [3:0]  POS_UNIT  = 4'h6;
    localparam logic [3:0]  POS_FUNC  = 4'h7;
    localparam logic [3:0]  POS_ADDR  = 4'h8;
    localparam logic [3:0]  POS_VAL   = 4'ha;
    localparam logic [15:0] QRY_LEN   = 16'h0006;
    localparam logic [7:0]  UNIT_LO   = 8'h00;
    localparam logic [7:0]  UNIT_HI   = 8'hff;
    localparam logic [7:0]  FC_READ   = 8'h03;
    localparam logic [7:0]  FC_WRITE  = 8'h06;
    localparam logic [7:0]  FC_DIAG   = 8'h08;
    localparam logic [15:0] SUB_ECHO  = 16'h0000;
    localparam logic [15:0] RD_MAX    = 16'h007d;
    // Holding area: index 0 is register 40001
    localparam logic [16:0] HOLD_WORDS = 17'h00400;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RECV, CHECK, SEND, HDR, RDREQ, RDWAIT, SENDHI, SENDLO
    } step_e;

    typedef struct packed {
        step_e            st;
        logic [11:0][7:0] buf_q;
        logic [3:0]       cnt;
        logic             ovf;
        logic             echo;
        logic             drain;
        logic [7:0]       idx;
        logic [6:0]       rcnt;
        logic [15:0]      raddr;
        logic [15:0]      rval;
        logic             rx_ready;
        logic             tx_valid;
        logic [7:0]       tx_data;
        logic             tx_last;
        logic             reg_we;
        logic             reg_re;
        logic [15:0]      reg_addr;
        logic [15:0]      reg_wdata;
    } srv_s;
endpackage

// ---- rtl/modbus_tcp_register_server.sv ----
// Purpose: server side of single-register write, echo and register read
// Assumes: rx/tx byte streams and register port share clock
// Notes:   refused queries are dropped without any answer
module modbus_tcp_register_server (
    input  wire logic        clock,     // 20 MHz clock
    input  wire logic        nrst,      // Synchronous reset, active low
    input  wire logic        rx_valid,  // Query byte offered
    input  wire logic [7:0]  rx_data,   // Query byte
    input  wire logic        rx_last,   // Last byte of query
    output logic             rx_ready,  // Query byte taken
    output logic             tx_valid,  // Answer byte offered
    output logic [7:0]       tx_data,   // Answer byte
    output logic             tx_last,   // Last byte of answer
    input  wire logic        tx_ready,  // Answer byte taken
    output logic             reg_we,    // Holding register write pulse
    output logic             reg_re,    // Holding register read pulse
    output logic [15:0]      reg_addr,  // Holding register index
    output logic [15:0]      reg_wdata, // Write value
    input  wire logic [15:0] reg_rdata  // Read value, sampled in the same cycle as reg_re
);
    mbt_pkg::srv_s s;
    mbt_pkg::srv_s next_s;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] word_at(input logic [11:0][7:0] b,
                                            input logic [3:0] p);
        return {b[p], b[p + 4'h1]};
    endfunction

    function automatic logic [7:0] hdr_byte(input logic [11:0][7:0] b,
                                            input logic [7:0] i,
                                            input logic [15:0] qty);
        logic [15:0] len;
        len = 16'h0003 + {qty[14:0], 1'b0};
        case (i)
            8'h00, 8'h01: hdr_byte = b[i[3:0]];
            8'h02, 8'h03: hdr_byte = 8'h00;
            8'h04: hdr_byte = len[15:8];
            8'h05: hdr_byte = len[7:0];
            8'h06, 8'h07: hdr_byte = b[i[3:0]];
            default: hdr_byte = {qty[6:0], 1'b0};
        endcase
    endfunction

    logic [15:0] q_len;
    logic [15:0] q_addr;
    logic [15:0] q_word;
    logic        hdr_ok;
    logic        slot;
    logic        acc;
    assign q_len  = word_at(s.buf_q, mbt_pkg::POS_LEN);
    assign q_addr = word_at(s.buf_q, mbt_pkg::POS_ADDR);
    assign q_word = word_at(s.buf_q, mbt_pkg::POS_VAL);
    assign hdr_ok = (s.cnt == 4'(mbt_pkg::QRY_BYTES)) && !s.ovf
        && (word_at(s.buf_q, mbt_pkg::POS_PROTO) == 16'h0000)
        && (q_len == mbt_pkg::QRY_LEN)
        && (s.buf_q[mbt_pkg::POS_UNIT] == mbt_pkg::UNIT_LO
            || s.buf_q[mbt_pkg::POS_UNIT] == mbt_pkg::UNIT_HI);
    assign acc  = s.tx_valid && tx_ready;
    assign slot = !s.tx_valid || tx_ready;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.reg_we = 1'b0;
        next_s.reg_re = 1'b0;
        if (acc) begin
            next_s.tx_valid = 1'b0;
        end
        case (s.st)
            mbt_pkg::RECV: begin
                if (rx_valid && s.rx_ready) begin
                    if (s.cnt < 4'(mbt_pkg::QRY_BYTES)) begin
                        next_s.buf_q[s.cnt] = rx_data;
                        next_s.cnt = s.cnt + 4'h1;
                    end else begin
                        next_s.ovf = 1'b1;
                    end
                    if (rx_last) begin
                        next_s.rx_ready = 1'b0;
                        next_s.st = mbt_pkg::CHECK;
                    end
                end
            end
            mbt_pkg::CHECK: begin
                next_s.idx = 8'h00;
                next_s.drain = 1'b0;
                next_s.st = mbt_pkg::SEND;
                next_s.echo = 1'b1;
                // Out-of-area accesses are dropped, no exception frame
                if (hdr_ok && s.buf_q[mbt_pkg::POS_FUNC] == mbt_pkg::FC_WRITE
                    && {1'b0, q_addr} < mbt_pkg::HOLD_WORDS) begin
                    next_s.reg_we = 1'b1;
                    next_s.reg_addr = q_addr;
                    next_s.reg_wdata = q_word;
                end else if (hdr_ok && s.buf_q[mbt_pkg::POS_FUNC] == mbt_pkg::FC_DIAG
                    && q_addr == mbt_pkg::SUB_ECHO) begin
                    next_s.echo = 1'b1;
                end else if (hdr_ok && s.buf_q[mbt_pkg::POS_FUNC] == mbt_pkg::FC_READ
                    && q_word != 16'h0000 && q_word <= mbt_pkg::RD_MAX
                    && {1'b0, q_addr} + {1'b0, q_word} <= mbt_pkg::HOLD_WORDS) begin
                    next_s.echo = 1'b0;
                    next_s.raddr = q_addr;
                    next_s.rcnt = q_word[6:0];
                    next_s.st = mbt_pkg::HDR;
                end else begin
                    next_s.st = mbt_pkg::RECV;
                    next_s.cnt = 4'h0;
                    next_s.ovf = 1'b0;
                    next_s.rx_ready = 1'b1;
                end
            end
            mbt_pkg::SEND, mbt_pkg::HDR: begin
                if (s.drain) begin
                    if (acc && s.tx_last) begin
                        next_s.st = mbt_pkg::RECV;
                        next_s.cnt = 4'h0;
                        next_s.ovf = 1'b0;
                        next_s.rx_ready = 1'b1;
                        next_s.tx_last = 1'b0;
                    end
                end else if (slot) begin
                    next_s.tx_valid = 1'b1;
                    next_s.idx = s.idx + 8'h01;
                    if (s.st == mbt_pkg::SEND) begin
                        next_s.tx_data = s.buf_q[s.idx[3:0]];
                        next_s.tx_last = (s.idx == 8'(mbt_pkg::QRY_BYTES - 1));
                        next_s.drain = next_s.tx_last;
                    end else begin
                        next_s.tx_data = hdr_byte(s.buf_q, s.idx, q_word);
                        if (s.idx == 8'(mbt_pkg::HDR_BYTES - 1)) begin
                            next_s.st = mbt_pkg::RDREQ;
                        end
                    end
                end
            end
            mbt_pkg::RDREQ: begin
                next_s.reg_re = 1'b1;
                next_s.reg_addr = s.raddr;
                next_s.st = mbt_pkg::RDWAIT;
            end
            mbt_pkg::RDWAIT: begin
                next_s.rval = reg_rdata;
                next_s.st = mbt_pkg::SENDHI;
            end
            mbt_pkg::SENDHI: begin
                if (slot) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_data = s.rval[15:8];
                    next_s.st = mbt_pkg::SENDLO;
                end
            end
            mbt_pkg::SENDLO: begin
                if (slot) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_data = s.rval[7:0];
                    next_s.tx_last = (s.rcnt == 7'h01);
                    next_s.rcnt = s.rcnt - 7'h01;
                    next_s.raddr = s.raddr + 16'h0001;
                    if (s.rcnt == 7'h01) begin
                        next_s.drain = 1'b1;
                        next_s.st = mbt_pkg::HDR;
                    end else begin
                        next_s.st = mbt_pkg::RDREQ;
                    end
                end
            end
            default: begin
                next_s.st = mbt_pkg::RECV;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s <= '0;
            s.st <= mbt_pkg::RECV;
            s.rx_ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rx_ready  = s.rx_ready;
    assign tx_valid  = s.tx_valid;
    assign tx_data   = s.tx_data;
    assign tx_last   = s.tx_last;
    assign reg_we    = s.reg_we;
    assign reg_re    = s.reg_re;
    assign reg_addr  = s.reg_addr;
    assign reg_wdata = s.reg_wdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_wr_value;
        @(posedge clock) disable iff (!nrst)
        s.reg_we |-> s.reg_wdata == {s.buf_q[10], s.buf_q[11]}
            && s.buf_q[7] == mbt_pkg::FC_WRITE;
    endproperty
    a_wr_value: assert property (p_wr_value) else $error("bad write value");

    property p_wr_addr;
        @(posedge clock) disable iff (!nrst)
        s.reg_we |-> s.reg_addr == {s.buf_q[8], s.buf_q[9]};
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("bad write address");

    property p_wr_area;
        @(posedge clock) disable iff (!nrst)
        s.reg_we |-> {1'b0, s.reg_addr} < mbt_pkg::HOLD_WORDS;
    endproperty
    a_wr_area: assert property (p_wr_area) else $error("write outside area");

    property p_proto_drop;
        @(posedge clock) disable iff (!nrst)
        (s.st == mbt_pkg::CHECK && {s.buf_q[2], s.buf_q[3]} != 16'h0000)
            |=> s.st == mbt_pkg::RECV ##1 !s.tx_valid;
    endproperty
    a_proto_drop: assert property (p_proto_drop) else $error("answered bad protocol");

    property p_unit;
        @(posedge clock) disable iff (!nrst)
        $rose(s.tx_valid) |-> s.buf_q[6] == mbt_pkg::UNIT_LO
            || s.buf_q[6] == mbt_pkg::UNIT_HI;
    endproperty
    a_unit: assert property (p_unit) else $error("answered bad unit");

    property p_echo;
        @(posedge clock) disable iff (!nrst)
        (s.tx_valid && s.echo) |-> s.tx_data == s.buf_q[4'(s.idx - 8'h01)];
    endproperty
    a_echo: assert property (p_echo) else $error("echo differs");

    property p_len;
        @(posedge clock) disable iff (!nrst)
        (s.tx_valid && !s.echo && s.idx == 8'h06)
            |-> s.tx_data == 8'(16'h0003 + 16'(2 * q_word));
    endproperty
    a_len: assert property (p_len) else $error("bad length");

    // Later requests also pass through this state, so only the first one is watched
    property p_count;
        @(posedge clock) disable iff (!nrst)
        (s.tx_valid && !s.echo && s.idx == 8'h09 && s.st == mbt_pkg::RDREQ
            && s.raddr == q_addr)
            |-> s.tx_data == {q_word[6:0], 1'b0} ##1 (s.reg_re && s.reg_addr == q_addr);
    endproperty
    a_count: assert property (p_count) else $error("bad byte count");

    property p_qty;
        @(posedge clock) disable iff (!nrst)
        s.reg_re |-> s.rcnt != 7'h00 && 16'(s.rcnt) <= mbt_pkg::RD_MAX;
    endproperty
    a_qty: assert property (p_qty) else $error("read quantity");

endmodule // modbus_tcp_register_server

// ---- tb/mbt_client.sv ----
// Purpose: client model that sends queries and sinks answers
// Assumes: one byte per handshake, the bench calls send
// Notes:   the sink stalls at random so held answer bytes are exercised
module mbt_client (
    input  wire logic       clock,    // Bench clock
    output logic            rx_valid, // Query byte offered
    output logic [7:0]      rx_data,  // Query byte
    output logic            rx_last,  // Last query byte
    input  wire logic       rx_ready, // Server takes byte
    output logic            tx_ready  // Answer byte taken
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
        tx_ready = 1'b0;
    end
    always @(posedge clock) begin
        tx_ready <= ($urandom_range(3) != 0);
    end
    // Each byte is held until the edge that takes it
    task automatic send(input logic [95:0] f);
        for (int i = 0; i < 12; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= f[95 - 8 * i -: 8];
            rx_last  <= (i == 11);
            do @(posedge clock); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data; // Released line must not show the last byte
        rx_last  <= 1'b0;
    endtask
endmodule // mbt_client

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the register server
// Assumes: 20 MHz clock, holding store modelled here
// Notes:   expected answer bytes are queued by the driver side
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, nrst, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic [7:0]  rx_data, tx_data;
    logic        reg_we, reg_re, prev_re;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, tr, a, v, w;
    logic [95:0] f;
    logic [71:0] hdr;
    logic [15:0] mem [0:1023];
    logic [95:0] bad [0:7];
    logic [8:0]  exp_q [$];
    int          errors, n_tests, n_we, cycles, n;
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        nrst = 1'b0;
        prev_re = 1'b0;
    end
    modbus_tcp_register_server u_modbus_tcp_register_server (
        .clock(clock), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .reg_we(reg_we), .reg_re(reg_re),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    mbt_client u_mbt_client (
        .clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_ready(rx_ready), .tx_ready(tx_ready));
    // --------------------------------------------------------------
    // Holding store, answer checker and timeout
    // --------------------------------------------------------------
    // Read data is only valid around a read; otherwise it changes every cycle
    always_comb reg_rdata = (reg_re === 1'b1 || prev_re) ? mem[reg_addr[9:0]] : cycles[15:0];
    always @(posedge clock) begin
        prev_re <= (reg_re === 1'b1);
        cycles++;
        if (reg_we === 1'b1) begin
            mem[reg_addr[9:0]] <= reg_wdata;
            n_we++;
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            n_tests++;
            if (exp_q.size() == 0) begin
                errors++;
                $display("Error %0t: unexpected answer byte", $time);
            end else begin
                if ({tx_last, tx_data} !== exp_q[0]) begin
                    errors++;
                    $display("Error %0t: answer byte %h, expected %h", $time, tx_data, exp_q[0]);
                end
                void'(exp_q.pop_front());
            end
        end
        if (cycles == 40000) begin
            errors++;
            $display("Error %0t: run timed out", $time);
            complete_run();
        end
    end
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    function automatic logic [95:0] mk(input logic [7:0] u, fc, input logic [15:0] p, l, x, y);
        return {tr, p, l, u, fc, x, y};
    endfunction
    task automatic push_echo(input logic [95:0] q);
        for (int i = 0; i < 12; i++) exp_q.push_back({i == 11, q[95 - 8 * i -: 8]});
    endtask
    task automatic run(input logic [95:0] q, input string name);
        u_mbt_client.send(q);
        repeat (3) @(posedge clock);
        for (int k = 0; k < 3000 && !(exp_q.size() == 0 && rx_ready === 1'b1); k++)
            @(posedge clock);
        n_tests++;
        if (exp_q.size() != 0 || rx_ready !== 1'b1) begin
            errors++;
            $display("Error %0t: answer missing in %s", $time, name);
        end
        $display("Test %s done", name);
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(91));
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        n_tests++;
        if (rx_ready !== 1'b1 || tx_valid !== 1'b0 || reg_we !== 1'b0) begin
            errors++;
            $display("Error %0t: outputs wrong after reset", $time);
        end
        // Writes: register 40014, last mapped word, random places
        for (int j = 0; j < 4; j++) begin
            tr = 16'($urandom);
            v = 16'($urandom);
            a = (j == 0) ? 16'h000d : (j == 1) ? 16'h03ff : 16'($urandom_range(1023));
            f = mk(j[0] ? 8'h00 : 8'hff, 8'h06, 16'h0000, 16'h0006, a, v);
            push_echo(f);
            run(f, "write");
            n_tests++;
            if (mem[a[9:0]] !== v) begin
                errors++;
                $display("Error %0t: holding word not stored", $time);
            end
        end
        // Echo data over the full range
        for (int j = 0; j < 3; j++) begin
            tr = 16'($urandom);
            v = (j == 0) ? 16'h0000 : (j == 1) ? 16'hffff : 16'($urandom);
            f = mk(j[0] ? 8'hff : 8'h00, 8'h08, 16'h0000, 16'h0006, 16'h0000, v);
            push_echo(f);
            run(f, "echo");
        end
        // Reads: three words, then 125 ending at the last mapped word
        for (int j = 0; j < 2; j++) begin
            tr = 16'($urandom);
            n = j ? 125 : 3;
            a = j ? 16'h0383 : 16'($urandom_range(1021));
            for (int k = 0; k < n; k++) mem[10'(a + k)] = 16'($urandom);
            f = mk(j ? 8'h00 : 8'hff, 8'h03, 16'h0000, 16'h0006, a, 16'(n));
            // Answer header is nine bytes: id, protocol, length, unit, function, count
            hdr = {tr, 16'h0000, 16'(3 + 2 * n), f[47:40], 8'h03, 8'(2 * n)};
            for (int i = 0; i < 9; i++) exp_q.push_back({1'b0, hdr[71 - 8 * i -: 8]});
            for (int k = 0; k < n; k++) begin
                w = mem[10'(a + k)];
                exp_q.push_back({1'b0, w[15:8]});
                exp_q.push_back({k == n - 1, w[7:0]});
            end
            run(f, "read");
        end
        // Refused queries: none may answer or write
        tr = 16'h5a5a;
        bad[0] = mk(8'hff, 8'h06, 16'h0001, 16'h0006, 16'h0000, 16'h1234);
        bad[1] = mk(8'h05, 8'h06, 16'h0000, 16'h0006, 16'h0000, 16'h1234);
        bad[2] = mk(8'hff, 8'h06, 16'h0000, 16'h0007, 16'h0000, 16'h1234);
        bad[3] = mk(8'hff, 8'h06, 16'h0000, 16'h0006, 16'h0400, 16'h1234);
        bad[4] = mk(8'hff, 8'h08, 16'h0000, 16'h0006, 16'h0001, 16'h1234);
        bad[5] = mk(8'hff, 8'h03, 16'h0000, 16'h0006, 16'h0000, 16'h0000);
        bad[6] = mk(8'hff, 8'h03, 16'h0000, 16'h0006, 16'h0000, 16'h007e);
        bad[7] = mk(8'hff, 8'h03, 16'h0000, 16'h0006, 16'h03ff, 16'h0002);
        for (int j = 0; j < 8; j++) run(bad[j], "refuse");
        n_tests++;
        if (n_we != 4) begin
            errors++;
            $display("Error %0t: write count %0d", $time, n_we);
        end
        complete_run();
    end
endmodule // tb_top
